// File: rtl/urp_pkg.sv
// Operation
// - Enable change flag shows change, write-one clears
// - Enable only by software, disable by software/fault
// - Enable bit follows actual state, waits for transactions
// - Connect change flag sets again, stays set
// - Connect change flag reads change, write-one clears
// - Connect status shows device presence now
// - Enable change set only on disconnect/end-of-frame fault
package urp_pkg;

   localparam int unsigned URP_ADR_W       = 8;
   localparam int unsigned URP_DAT_W       = 32;
   localparam int unsigned URP_IRQ_W       = 2;

   localparam logic [URP_ADR_W-1:0] URP_OFS_PORT_SC  = 8'h00;
   localparam logic [URP_ADR_W-1:0] URP_OFS_IRQ_STAT = 8'h04;
   localparam logic [URP_ADR_W-1:0] URP_OFS_IRQ_CLR  = 8'h08;
   localparam logic [URP_ADR_W-1:0] URP_OFS_IRQ_EN   = 8'h0C;

   localparam int unsigned URP_BIT_CONN    = 0;
   localparam int unsigned URP_BIT_CONN_CH = 1;
   localparam int unsigned URP_BIT_PORT_EN = 2;
   localparam int unsigned URP_BIT_EN_CH   = 3;

   localparam int unsigned URP_IRQ_CONN    = 0;
   localparam int unsigned URP_IRQ_EN      = 1;

   localparam logic [URP_IRQ_W-1:0] URP_IRQ_RST = 2'h0;
   localparam logic [URP_DAT_W-1:0] URP_DAT_ZERO = 32'h00000000;

   typedef enum logic [1:0] {
      URP_DISABLED  = 2'b00,
      URP_ENABLING  = 2'b01,
      URP_ENABLED   = 2'b10,
      URP_DISABLING = 2'b11
   } urp_state_e;

endpackage : urp_pkg

// File: rtl/urp_root_port.sv
`timescale 1ns/10ps
`default_nettype none
module urp_root_port
   import urp_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic                 reset,
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [URP_ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic [URP_DAT_W-1:0] wb_dat_i,
   output logic      [URP_DAT_W-1:0] wb_dat_o,
   output logic                      wb_ack_o,
   input  wire logic                 dev_present,
   input  wire logic                 usb_busy,
   input  wire logic                 eof2_fault,
   output logic                      port_enabled,
   output logic                      irq
);

   typedef struct packed {
      logic                 ack;
      logic [URP_DAT_W-1:0] rdata;
      logic                 conn;
      logic                 conn_ch;
      logic                 en_ch;
      logic                 hw_cause;
      urp_state_e           state;
      logic [URP_IRQ_W-1:0] irq_stat;
      logic [URP_IRQ_W-1:0] irq_en;
   } urp_state_s;

   urp_state_s r;
   urp_state_s next_r;

   logic conn_sync;
   logic access;
   logic wr_lane0;
   logic sc_write;
   logic sw_enable;
   logic sw_disable;
   logic conn_edge;
   logic disconnect;
   logic fault;
   logic conn_ch_clr;
   logic en_ch_clr;
   logic en_ch_set;
   logic [URP_IRQ_W-1:0] irq_set;
   logic [URP_IRQ_W-1:0] irq_clr;
   logic [URP_DAT_W-1:0] rd_mux;

   urp_sync2 u_present_sync (
      .clk      (clk),
      .reset    (reset),
      .async_in (dev_present),
      .sync_out (conn_sync)
   );

   // Bus access is taken in the cycle before ack rises; ack lasts one cycle
   assign access      = wb_cyc_i & wb_stb_i & ~r.ack;
   assign wr_lane0    = access & wb_we_i & wb_sel_i[0];
   assign sc_write    = wr_lane0 & (wb_adr_i == URP_OFS_PORT_SC);
   assign sw_enable   = sc_write & wb_dat_i[URP_BIT_PORT_EN];
   assign sw_disable  = sc_write & ~wb_dat_i[URP_BIT_PORT_EN];
   assign conn_edge   = conn_sync ^ r.conn;
   assign disconnect  = r.conn & ~conn_sync;
   assign fault       = disconnect | eof2_fault;
   assign conn_ch_clr = sc_write & wb_dat_i[URP_BIT_CONN_CH];
   assign en_ch_clr   = sc_write & wb_dat_i[URP_BIT_EN_CH];
   assign en_ch_set   = (r.state == URP_DISABLING) & ~usb_busy & r.hw_cause;
   assign irq_set     = {en_ch_set, conn_edge};
   assign irq_clr     = (wr_lane0 & (wb_adr_i == URP_OFS_IRQ_CLR)) ?
                        wb_dat_i[URP_IRQ_W-1:0] : URP_IRQ_RST;

   always_comb begin
      rd_mux = URP_DAT_ZERO;
      unique case (wb_adr_i)
         URP_OFS_PORT_SC: begin
            rd_mux[URP_BIT_CONN]    = r.conn;
            rd_mux[URP_BIT_CONN_CH] = r.conn_ch;
            rd_mux[URP_BIT_PORT_EN] = (r.state == URP_ENABLED) |
                                      (r.state == URP_DISABLING);
            rd_mux[URP_BIT_EN_CH]   = r.en_ch;
         end
         URP_OFS_IRQ_STAT: begin
            rd_mux[URP_IRQ_W-1:0] = r.irq_stat;
         end
         URP_OFS_IRQ_EN: begin
            rd_mux[URP_IRQ_W-1:0] = r.irq_en;
         end
         default: begin
            rd_mux = URP_DAT_ZERO;
         end
      endcase
   end

   always_comb begin
      next_r       = r;
      next_r.ack   = access;
      if (access & ~wb_we_i) begin
         next_r.rdata = rd_mux;
      end
      next_r.conn = conn_sync;
      // Set wins over a same-cycle clear on every sticky bit
      next_r.conn_ch = (r.conn_ch & ~conn_ch_clr) | conn_edge;
      next_r.en_ch   = (r.en_ch & ~en_ch_clr) | en_ch_set;
      next_r.irq_stat = (r.irq_stat & ~irq_clr) | irq_set;
      if (wr_lane0 & (wb_adr_i == URP_OFS_IRQ_EN)) begin
         next_r.irq_en = wb_dat_i[URP_IRQ_W-1:0];
      end
      unique case (r.state)
         URP_DISABLED: begin
            // Only a software write starts enabling, and only with a device present
            if (sw_enable & conn_sync & r.conn) begin
               next_r.state = URP_ENABLING;
            end
         end
         URP_ENABLING: begin
            if (fault | sw_disable) begin
               next_r.state = URP_DISABLED;
            end else if (~usb_busy) begin
               next_r.state = URP_ENABLED;
            end
         end
         URP_ENABLED: begin
            if (fault) begin
               next_r.state    = URP_DISABLING;
               next_r.hw_cause = 1'b1;
            end else if (sw_disable) begin
               next_r.state    = URP_DISABLING;
               next_r.hw_cause = 1'b0;
            end
         end
         URP_DISABLING: begin
            // A running transaction delays the actual disable
            if (~usb_busy) begin
               next_r.state    = URP_DISABLED;
               next_r.hw_cause = 1'b0;
            end else if (fault) begin
               next_r.hw_cause = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         r          <= '0;
         r.state    <= URP_DISABLED;
         r.irq_stat <= URP_IRQ_RST;
         r.irq_en   <= URP_IRQ_RST;
      end else begin
         r <= next_r;
      end
   end

   assign wb_ack_o     = r.ack;
   assign wb_dat_o     = r.rdata;
   assign port_enabled = (r.state == URP_ENABLED) | (r.state == URP_DISABLING);
   assign irq          = |(r.irq_stat & r.irq_en);

   property p_en_ch_hw_only;
      @(posedge clk) disable iff (reset)
      $rose(r.en_ch) |-> ($past(r.state) == URP_DISABLING) && $past(r.hw_cause);
   endproperty
   a_en_ch_hw_only: assert property (p_en_ch_hw_only)
      else $error("enable change set without a hardware disable");

   property p_en_ch_clear;
      @(posedge clk) disable iff (reset)
      (en_ch_clr && !en_ch_set) |=> !r.en_ch;
   endproperty
   a_en_ch_clear: assert property (p_en_ch_clear)
      else $error("enable change flag not cleared by write of one");

   property p_enable_by_sw;
      @(posedge clk) disable iff (reset)
      (r.state == URP_ENABLING && $past(r.state) == URP_DISABLED) |-> $past(sw_enable);
   endproperty
   a_enable_by_sw: assert property (p_enable_by_sw)
      else $error("port enabling started without a software write");

   property p_busy_delays;
      @(posedge clk) disable iff (reset)
      (r.state == URP_DISABLING && usb_busy) |=> port_enabled;
   endproperty
   a_busy_delays: assert property (p_busy_delays)
      else $error("port disabled while a transaction was running");

   property p_disconnect_disables;
      @(posedge clk) disable iff (reset)
      (disconnect && r.state == URP_ENABLED) |=> (r.state == URP_DISABLING) && r.hw_cause;
   endproperty
   a_disconnect_disables: assert property (p_disconnect_disables)
      else $error("disconnect did not disable the port");

   property p_conn_ch_set;
      @(posedge clk) disable iff (reset)
      conn_edge |=> r.conn_ch && r.irq_stat[URP_IRQ_CONN];
   endproperty
   a_conn_ch_set: assert property (p_conn_ch_set)
      else $error("connect change not flagged");

   property p_conn_ch_clear;
      @(posedge clk) disable iff (reset)
      (conn_ch_clr && !conn_edge) |=> !r.conn_ch;
   endproperty
   a_conn_ch_clear: assert property (p_conn_ch_clear)
      else $error("connect change flag not cleared by write of one");

   property p_conn_read;
      @(posedge clk) disable iff (reset)
      (access && !wb_we_i && wb_adr_i == URP_OFS_PORT_SC) |=>
         wb_ack_o && (wb_dat_o[URP_BIT_CONN] == $past(r.conn));
   endproperty
   a_conn_read: assert property (p_conn_read)
      else $error("connect status read back wrong");

   property p_stay_enabled;
      @(posedge clk) disable iff (reset)
      (r.state == URP_ENABLED && !fault && !sw_disable) |=> (r.state == URP_ENABLED);
   endproperty
   a_stay_enabled: assert property (p_stay_enabled)
      else $error("port left the enabled state without a cause");

   property p_stay_disabled;
      @(posedge clk) disable iff (reset)
      (r.state == URP_DISABLED && !sw_enable) |=> (r.state == URP_DISABLED);
   endproperty
   a_stay_disabled: assert property (p_stay_disabled)
      else $error("port left the disabled state without a software write");

   property p_enable_needs_dev;
      @(posedge clk) disable iff (reset)
      (r.state == URP_DISABLED && !r.conn) |=> (r.state == URP_DISABLED);
   endproperty
   a_enable_needs_dev: assert property (p_enable_needs_dev)
      else $error("enabling started with no device attached");

   property p_enabling_waits;
      @(posedge clk) disable iff (reset)
      (r.state == URP_ENABLING && usb_busy) |=> !port_enabled;
   endproperty
   a_enabling_waits: assert property (p_enabling_waits)
      else $error("port enabled while a transaction was running");

   property p_eof2_disables;
      @(posedge clk) disable iff (reset)
      (eof2_fault && r.state == URP_ENABLED) |=> (r.state == URP_DISABLING) && r.hw_cause;
   endproperty
   a_eof2_disables: assert property (p_eof2_disables)
      else $error("end-of-frame fault did not start a disable");

   property p_disable_done;
      @(posedge clk) disable iff (reset)
      (r.state == URP_DISABLING && !usb_busy && r.hw_cause) |=>
         !port_enabled && r.en_ch && r.irq_stat[URP_IRQ_EN];
   endproperty
   a_disable_done: assert property (p_disable_done)
      else $error("fault disable did not flag an enable change");

   property p_sw_disable_quiet;
      @(posedge clk) disable iff (reset)
      (r.state == URP_DISABLING && !r.hw_cause && !r.en_ch) |=> !r.en_ch;
   endproperty
   a_sw_disable_quiet: assert property (p_sw_disable_quiet)
      else $error("software disable flagged an enable change");

   property p_en_ch_holds;
      @(posedge clk) disable iff (reset)
      (r.en_ch && !en_ch_clr) |=> r.en_ch;
   endproperty
   a_en_ch_holds: assert property (p_en_ch_holds)
      else $error("enable change flag lost without a clear");

   property p_conn_ch_holds;
      @(posedge clk) disable iff (reset)
      (r.conn_ch && !conn_ch_clr) |=> r.conn_ch;
   endproperty
   a_conn_ch_holds: assert property (p_conn_ch_holds)
      else $error("connect change flag lost without a clear");

   property p_conn_ch_quiet;
      @(posedge clk) disable iff (reset)
      (!r.conn_ch && !conn_edge) |=> !r.conn_ch;
   endproperty
   a_conn_ch_quiet: assert property (p_conn_ch_quiet)
      else $error("connect change flagged with no change");

   property p_conn_follows;
      @(posedge clk) disable iff (reset)
      1'b1 |=> (r.conn == $past(conn_sync));
   endproperty
   a_conn_follows: assert property (p_conn_follows)
      else $error("connect status does not follow the synced pin");

   property p_ack_on_access;
      @(posedge clk) disable iff (reset)
      access |=> wb_ack_o;
   endproperty
   a_ack_on_access: assert property (p_ack_on_access)
      else $error("bus access not acknowledged");

   property p_ack_single;
      @(posedge clk) disable iff (reset)
      wb_ack_o |=> !wb_ack_o;
   endproperty
   a_ack_single: assert property (p_ack_single)
      else $error("ack held longer than one cycle");

endmodule // urp_root_port
`default_nettype wire

// File: rtl/urp_sync2.sv
`timescale 1ns/10ps
`default_nettype none
module urp_sync2 (
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic async_in,
   output logic      sync_out
);

   typedef struct packed {
      logic meta;
      logic stable;
   } urp_sync_s;

   urp_sync_s r;
   urp_sync_s next_r;

   // The first stage feeds only the second stage
   always_comb begin
      next_r        = r;
      next_r.meta   = async_in;
      next_r.stable = r.meta;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign sync_out = r.stable;

endmodule // urp_sync2
`default_nettype wire

// File: test/urp_root_port_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module urp_root_port_tb_top;
   import urp_pkg::*;
   logic        clk = 1'b0;
   logic        reset = 1'b1;
   logic        cyc = 1'b0, stb = 1'b0, wwe = 1'b0, eof2 = 1'b0, plug = 1'b0, xfer = 1'b0;
   logic [7:0]  adr = 8'h00;
   logic [3:0]  sel = 4'hF;
   logic [31:0] wdat = 32'h0, rdat, r;
   logic        ack, pen, irq, pres, busy;
   logic [31:0] q[$];
   int          error_cnt = 0, cmp_count = 0, seed = 71;

   always #5 clk = ~clk;

   urp_usb_dev dev (.clk(clk), .plug(plug), .xfer(xfer), .dev_present(pres), .usb_busy(busy));
   urp_root_port dut (.clk(clk), .reset(reset), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(wwe), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .dev_present(pres), .usb_busy(busy), .eof2_fault(eof2),
      .port_enabled(pen), .irq(irq));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wrap_up;
      $display("compares %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask

   // Ack sampled before its own edge updates land, so no race on the drop
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      cyc <= 1'b1; stb <= 1'b1; wwe <= we; adr <= a; wdat <= d;
      @(posedge clk);
      while (ack !== 1'b1 && n < 50) begin
         @(posedge clk);
         n++;
      end
      if (n >= 50) error_cnt++;
      cyc <= 1'b0; stb <= 1'b0; wwe <= 1'b0;
      @(posedge clk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      q.push_back(e);
      wb(1'b0, a, 32'h0);
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic fin(input int t);
      $display("test %0d done", t);
   endtask

   always @(posedge clk) begin
      if (ack === 1'b1 && wwe === 1'b0) begin
         if (q.size() > 0) check(rdat, q.pop_front());
         else check(32'hFFFFFFFF, 32'h0);
      end
   end

   initial begin
      idle(20000);
      error_cnt++;
      wrap_up();
   end

   initial begin
      idle(2);
      reset <= 1'b0;
      rd(8'h00, 32'h0);
      rd(8'h10, 32'h0);
      rd(8'h0C, 32'h0);
      fin(1);
      plug <= 1'b1;
      idle(6);
      rd(8'h00, 32'h3);
      rd(8'h04, 32'h1);
      wb(1'b1, 8'h00, 32'h2);
      rd(8'h00, 32'h1);
      fin(2);
      xfer <= 1'b1;
      wb(1'b1, 8'h00, 32'h4);
      idle(4);
      check({31'h0, pen}, 32'h0);
      xfer <= 1'b0;
      idle(4);
      rd(8'h00, 32'h5);
      wb(1'b1, 8'h00, 32'h0);
      idle(3);
      rd(8'h00, 32'h1);
      fin(3);
      wb(1'b1, 8'h00, 32'h4);
      idle(3);
      eof2 <= 1'b1;
      idle(1);
      eof2 <= 1'b0;
      idle(3);
      rd(8'h00, 32'h9);
      rd(8'h04, 32'h3);
      wb(1'b1, 8'h0C, 32'h3);
      check({31'h0, irq}, 32'h1);
      wb(1'b1, 8'h08, 32'h3);
      idle(1);
      check({31'h0, irq}, 32'h0);
      rd(8'h04, 32'h0);
      wb(1'b1, 8'h00, 32'h8);
      rd(8'h00, 32'h1);
      fin(4);
      r = $random(seed);
      wb(1'b1, 8'h0C, r);
      rd(8'h0C, r & 32'h3);
      wb(1'b1, 8'h10, r);
      rd(8'h10, 32'h0);
      wb(1'b1, 8'h04, r);
      rd(8'h04, 32'h0);
      wb(1'b1, 8'h0C, 32'h3);
      sel <= 4'hE;
      wb(1'b1, 8'h0C, 32'h0);
      sel <= 4'hF;
      rd(8'h0C, 32'h3);
      rd(8'h08, 32'h0);
      fin(5);
      wb(1'b1, 8'h00, 32'h4);
      idle(3);
      xfer <= 1'b1;
      wb(1'b1, 8'h00, 32'h0);
      idle(2);
      check({31'h0, pen}, 32'h1);
      xfer <= 1'b0;
      idle(4);
      check({31'h0, pen}, 32'h0);
      rd(8'h00, 32'h1);
      wb(1'b1, 8'h00, 32'h4);
      idle(3);
      plug <= 1'b0;
      idle(8);
      rd(8'h00, 32'hA);
      check({31'h0, pen}, 32'h0);
      check({31'h0, irq}, 32'h1);
      wb(1'b1, 8'h08, 32'h3);
      wb(1'b1, 8'h00, 32'hA);
      rd(8'h00, 32'h0);
      check({31'h0, irq}, 32'h0);
      fin(6);
      // Attach, detach, attach before any clear: flag just stays set
      plug <= 1'b1;
      idle(5);
      plug <= 1'b0;
      idle(5);
      plug <= 1'b1;
      idle(6);
      rd(8'h00, 32'h3);
      fin(7);
      wrap_up();
   end
endmodule // urp_root_port_tb_top
`default_nettype wire

// File: test/urp_usb_dev.sv
`timescale 1ns/10ps
`default_nettype none
// Attached device: presence pin and transaction activity, no free-running link clock
module urp_usb_dev (
   input  wire logic clk,
   input  wire logic plug,
   input  wire logic xfer,
   output logic      dev_present,
   output logic      usb_busy
);
   always_ff @(posedge clk) begin
      dev_present <= plug;
      usb_busy    <= xfer;
   end
endmodule // urp_usb_dev
`default_nettype wire
